// >>> rtl/tccu_top.sv
// Timer capture/compare unit: two timebases, five compare outputs, five capture inputs, register port.
// What this block does
// - Five compare channels, one output pin each.
// - Compare modes: PWM, pulses, single, toggle, low, high.
// - Each compare channel picks timebase A or B.
// - Five capture channels, each watching one pin.
// - Qualifying pin edge latches selected timebase count.
// - Each capture channel picks timebase A or B.
// - Capture on rising, falling or both edges.
// - Capture event can raise an interrupt request.
// - Four-entry FIFO per capture channel, arrival order.
// - Two 16-bit timebases, joinable into 32 bits.
// - Count on prescaled clock, reset at period.
//
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module tccu_top (
	// Clock and reset.
	input  wire logic                          sys_clk,
	input  wire logic                          rst,
	// Register port.
	input  wire logic [tccu_pkg::ADDR_W-1:0]   reg_addr,
	input  wire logic [tccu_pkg::DATA_W-1:0]   reg_wdata,
	input  wire logic                          reg_wr,
	input  wire logic                          reg_rd,
	output logic      [tccu_pkg::DATA_W-1:0]   reg_rdata,
	// Compare output pins.
	output logic                               compare_output_pin_1,
	output logic                               compare_output_pin_2,
	output logic                               compare_output_pin_3,
	output logic                               compare_output_pin_4,
	output logic                               compare_output_pin_5,
	// Capture input pins.
	input  wire logic                          capture_input_pin_1,
	input  wire logic                          capture_input_pin_2,
	input  wire logic                          capture_input_pin_3,
	input  wire logic                          capture_input_pin_4,
	input  wire logic                          capture_input_pin_5,
	// Capture interrupt requests, one per channel.
	output logic      [tccu_pkg::NUM_CH-1:0]   capture_irq
);
	import tccu_pkg::*;

	// Timebase configuration and state.
	logic                  tb_en_a;
	logic                  tb_en_b;
	logic                  tb_join;
	logic [PSC_SEL_W-1:0]  tb_psc_a;
	logic [PSC_SEL_W-1:0]  tb_psc_b;
	logic [TB_W-1:0]       tb_period_a;
	logic [TB_W-1:0]       tb_period_b;
	logic [TB_W-1:0]       count_a;
	logic [TB_W-1:0]       count_b;
	logic                  wrap_a;
	logic                  step_a;
	logic                  step_b;

	// Compare channel configuration and state.
	logic [CMP_MODE_W-1:0] cmp_mode  [NUM_CH];
	logic                  cmp_tbsel [NUM_CH];
	logic                  cmp_en    [NUM_CH];
	logic [TB_W-1:0]       cmp_val   [NUM_CH];
	logic [TB_W-1:0]       cmp_aux   [NUM_CH];
	logic [NUM_CH-1:0]     cmp_ctrl_wr;
	logic [NUM_CH-1:0]     cmp_pin;

	// Capture channel configuration and state.
	logic [CAP_EDGE_W-1:0] cap_edge   [NUM_CH];
	logic                  cap_tbsel  [NUM_CH];
	logic                  cap_en     [NUM_CH];
	logic                  cap_irq_en [NUM_CH];
	logic [TB_W-1:0]       cap_head   [NUM_CH];
	logic [LEVEL_W-1:0]    cap_level  [NUM_CH];
	logic [NUM_CH-1:0]     cap_ovf;
	logic [NUM_CH-1:0]     cap_event;
	logic [NUM_CH-1:0]     cap_pop;
	logic [NUM_CH-1:0]     cap_pin;
	logic [DATA_W-1:0]     next_rdata;

	assign cap_pin = {capture_input_pin_5, capture_input_pin_4, capture_input_pin_3,
		capture_input_pin_2, capture_input_pin_1};

	// Compare pins leave straight from their flip-flops.
	assign compare_output_pin_1 = cmp_pin[0];
	assign compare_output_pin_2 = cmp_pin[1];
	assign compare_output_pin_3 = cmp_pin[2];
	assign compare_output_pin_4 = cmp_pin[3];
	assign compare_output_pin_5 = cmp_pin[4];

	// Timebase registers.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			tb_en_a     <= 1'b0;
			tb_en_b     <= 1'b0;
			tb_join     <= 1'b0;
			tb_psc_a    <= '0;
			tb_psc_b    <= '0;
			tb_period_a <= TB_PERIOD_RST;
			tb_period_b <= TB_PERIOD_RST;
		end else if (reg_wr) begin
			if (reg_addr == TB_CTRL_OFS) begin
				tb_en_a  <= reg_wdata[TB_EN_A_BIT];
				tb_en_b  <= reg_wdata[TB_EN_B_BIT];
				tb_join  <= reg_wdata[TB_JOIN_BIT];
				tb_psc_a <= reg_wdata[TB_PSC_A_LSB +: PSC_SEL_W];
				tb_psc_b <= reg_wdata[TB_PSC_B_LSB +: PSC_SEL_W];
			end
			if (reg_addr == TB_A_PERIOD_OFS) begin
				tb_period_a <= reg_wdata[TB_W-1:0];
			end
			if (reg_addr == TB_B_PERIOD_OFS) begin
				tb_period_b <= reg_wdata[TB_W-1:0];
			end
		end
	end

	// Timebase A is always the low half; joined, B counts A's wraps and forms the high half.
	tccu_timebase #(.W(TB_W), .PSC_W(PSC_W)) u_tb_a (
		.sys_clk      (sys_clk),
		.rst          (rst),
		.enable       (tb_en_a),
		.prescale_sel (tb_psc_a),
		.period       (tb_period_a),
		.chain_mode   (1'b0),
		.chain_tick   (1'b0),
		.count        (count_a),
		.wrap         (wrap_a),
		.step         (step_a)
	);

	tccu_timebase #(.W(TB_W), .PSC_W(PSC_W)) u_tb_b (
		.sys_clk      (sys_clk),
		.rst          (rst),
		.enable       (tb_join ? tb_en_a : tb_en_b),
		.prescale_sel (tb_psc_b),
		.period       (tb_period_b),
		.chain_mode   (tb_join),
		.chain_tick   (wrap_a),
		.count        (count_b),
		.wrap         (),
		.step         (step_b)
	);

	// Channel configuration registers; a compare control write re-arms a single pulse.
	always_ff @(posedge sys_clk) begin
		for (int i = 0; i < NUM_CH; i++) begin
			if (rst) begin
				cmp_mode[i]   <= CMP_RISE;
				cmp_tbsel[i]  <= 1'b0;
				cmp_en[i]     <= 1'b0;
				cmp_val[i]    <= '0;
				cmp_aux[i]    <= '0;
				cap_edge[i]   <= CAP_RISING;
				cap_tbsel[i]  <= 1'b0;
				cap_en[i]     <= 1'b0;
				cap_irq_en[i] <= 1'b0;
			end else if (reg_wr) begin
				if (reg_addr == tccu_ch_addr(CMP_BASE, i, CH_CTRL_SUB)) begin
					cmp_mode[i]  <= reg_wdata[CMP_MODE_LSB +: CMP_MODE_W];
					cmp_tbsel[i] <= reg_wdata[CMP_TBSEL_BIT];
					cmp_en[i]    <= reg_wdata[CMP_EN_BIT];
				end
				if (reg_addr == tccu_ch_addr(CMP_BASE, i, CH_VAL_SUB)) begin
					cmp_val[i] <= reg_wdata[TB_W-1:0];
				end
				if (reg_addr == tccu_ch_addr(CMP_BASE, i, CH_AUX_SUB)) begin
					cmp_aux[i] <= reg_wdata[TB_W-1:0];
				end
				if (reg_addr == tccu_ch_addr(CAP_BASE, i, CH_CTRL_SUB)) begin
					cap_edge[i]   <= reg_wdata[CAP_EDGE_LSB +: CAP_EDGE_W];
					cap_tbsel[i]  <= reg_wdata[CAP_TBSEL_BIT];
					cap_en[i]     <= reg_wdata[CAP_EN_BIT];
					cap_irq_en[i] <= reg_wdata[CAP_IRQ_EN_BIT];
				end
			end
		end
	end

	// Strobe decode for re-arm and FIFO pop.
	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			cmp_ctrl_wr[i] = reg_wr & (reg_addr == tccu_ch_addr(CMP_BASE, i, CH_CTRL_SUB));
			cap_pop[i]     = reg_rd & (reg_addr == tccu_ch_addr(CAP_BASE, i, CH_VAL_SUB));
		end
	end

	// Compare channels; matches count once per timebase step so toggles do not chatter under a prescaler.
	for (genvar gi = 0; gi < NUM_CH; gi++) begin : g_cmp
		logic [TB_W-1:0] cnt;
		logic            stp;
		logic            hit_on;
		logic            hit_off;
		logic            done;

		assign cnt     = cmp_tbsel[gi] ? count_b : count_a;
		assign stp     = cmp_tbsel[gi] ? step_b : step_a;
		assign hit_on  = stp & (cnt == cmp_val[gi]);
		assign hit_off = stp & (cnt == cmp_aux[gi]);

		// Pin behaviour per mode; the two spare codes hold the pin.
		always_ff @(posedge sys_clk) begin
			if (rst || !cmp_en[gi]) begin
				cmp_pin[gi] <= 1'b0;
				done        <= 1'b0;
			end else begin
				if (cmp_ctrl_wr[gi]) begin
					done <= 1'b0;
				end
				unique case (tccu_cmp_mode_t'(cmp_mode[gi]))
					CMP_RISE: begin
						if (hit_on) cmp_pin[gi] <= 1'b1;
					end
					CMP_FALL: begin
						if (hit_on) cmp_pin[gi] <= 1'b0;
					end
					CMP_TOGGLE: begin
						if (hit_on) cmp_pin[gi] <= ~cmp_pin[gi];
					end
					CMP_SINGLE: begin
						if (hit_on && !done) begin
							cmp_pin[gi] <= 1'b1;
						end else if (hit_off && cmp_pin[gi]) begin
							cmp_pin[gi] <= 1'b0;
							done        <= 1'b1;
						end
					end
					CMP_CONT: begin
						if (hit_on) begin
							cmp_pin[gi] <= 1'b1;
						end else if (hit_off) begin
							cmp_pin[gi] <= 1'b0;
						end
					end
					CMP_PWM: begin
						cmp_pin[gi] <= (cnt < cmp_val[gi]);
					end
					default: begin
						cmp_pin[gi] <= cmp_pin[gi];
					end
				endcase
			end
		end
	end

	// Capture channels.
	for (genvar gi = 0; gi < NUM_CH; gi++) begin : g_cap
		tccu_capture #(.W(TB_W), .DEPTH(FIFO_DEPTH)) u_cap (
			.sys_clk       (sys_clk),
			.rst           (rst),
			.enable        (cap_en[gi]),
			.edge_mode     (cap_edge[gi]),
			.tb_sel        (cap_tbsel[gi]),
			.count_a       (count_a),
			.count_b       (count_b),
			.pin           (cap_pin[gi]),
			.pop           (cap_pop[gi]),
			.head          (cap_head[gi]),
			.level         (cap_level[gi]),
			.overflow      (cap_ovf[gi]),
			.capture_event (cap_event[gi])
		);
	end

	// Interrupt request pulses one cycle after each enabled capture event.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			capture_irq <= '0;
		end else begin
			for (int i = 0; i < NUM_CH; i++) begin
				capture_irq[i] <= cap_event[i] & cap_irq_en[i];
			end
		end
	end

	// Read mux; unmapped addresses read as zero.
	always_comb begin
		next_rdata = '0;
		unique case (reg_addr)
			TB_CTRL_OFS: begin
				next_rdata[TB_EN_A_BIT]                   = tb_en_a;
				next_rdata[TB_EN_B_BIT]                   = tb_en_b;
				next_rdata[TB_JOIN_BIT]                   = tb_join;
				next_rdata[TB_PSC_A_LSB +: PSC_SEL_W]     = tb_psc_a;
				next_rdata[TB_PSC_B_LSB +: PSC_SEL_W]     = tb_psc_b;
			end
			TB_A_PERIOD_OFS: next_rdata[TB_W-1:0] = tb_period_a;
			TB_B_PERIOD_OFS: next_rdata[TB_W-1:0] = tb_period_b;
			TB_A_COUNT_OFS:  next_rdata[TB_W-1:0] = count_a;
			TB_B_COUNT_OFS:  next_rdata[TB_W-1:0] = count_b;
			default:         next_rdata = '0;
		endcase
		for (int i = 0; i < NUM_CH; i++) begin
			if (reg_addr == tccu_ch_addr(CMP_BASE, i, CH_CTRL_SUB)) begin
				next_rdata[CMP_MODE_LSB +: CMP_MODE_W] = cmp_mode[i];
				next_rdata[CMP_TBSEL_BIT]              = cmp_tbsel[i];
				next_rdata[CMP_EN_BIT]                 = cmp_en[i];
			end
			if (reg_addr == tccu_ch_addr(CMP_BASE, i, CH_VAL_SUB)) next_rdata[TB_W-1:0] = cmp_val[i];
			if (reg_addr == tccu_ch_addr(CMP_BASE, i, CH_AUX_SUB)) next_rdata[TB_W-1:0] = cmp_aux[i];
			if (reg_addr == tccu_ch_addr(CAP_BASE, i, CH_CTRL_SUB)) begin
				next_rdata[CAP_EDGE_LSB +: CAP_EDGE_W] = cap_edge[i];
				next_rdata[CAP_TBSEL_BIT]              = cap_tbsel[i];
				next_rdata[CAP_EN_BIT]                 = cap_en[i];
				next_rdata[CAP_IRQ_EN_BIT]             = cap_irq_en[i];
			end
			if (reg_addr == tccu_ch_addr(CAP_BASE, i, CH_VAL_SUB)) next_rdata[TB_W-1:0] = cap_head[i];
			if (reg_addr == tccu_ch_addr(CAP_BASE, i, CH_AUX_SUB)) begin
				next_rdata[CAP_NEMPTY_BIT]             = (cap_level[i] != '0);
				next_rdata[CAP_OVF_BIT]                = cap_ovf[i];
				next_rdata[CAP_LEVEL_LSB +: LEVEL_W]   = cap_level[i];
			end
		end
	end

	// Read data stand only in the cycle after the strobe.
	always_ff @(posedge sys_clk) begin
		if (rst || !reg_rd) begin
			reg_rdata <= RDATA_RST;
		end else begin
			reg_rdata <= next_rdata;
		end
	end

endmodule : tccu_top

// >>> inc/tccu_pkg.sv
// Shared constants, register map and mode encodings of the timer capture/compare unit.
package tccu_pkg;

	// Structure.
	localparam int NUM_CH     = 5;
	localparam int TB_W       = 16;
	localparam int FIFO_DEPTH = 4;
	localparam int PSC_W      = 8;
	localparam int PSC_SEL_W  = 3;
	localparam int ADDR_W     = 8;
	localparam int DATA_W     = 32;
	localparam int CH_SHIFT   = 4;

	// Register byte offsets.
	localparam logic [ADDR_W-1:0] TB_CTRL_OFS     = 8'h00;
	localparam logic [ADDR_W-1:0] TB_A_PERIOD_OFS = 8'h04;
	localparam logic [ADDR_W-1:0] TB_B_PERIOD_OFS = 8'h08;
	localparam logic [ADDR_W-1:0] TB_A_COUNT_OFS  = 8'h0C;
	localparam logic [ADDR_W-1:0] TB_B_COUNT_OFS  = 8'h10;
	localparam logic [ADDR_W-1:0] CMP_BASE        = 8'h20;
	localparam logic [ADDR_W-1:0] CAP_BASE        = 8'h80;
	localparam logic [ADDR_W-1:0] CH_CTRL_SUB     = 8'h00;
	localparam logic [ADDR_W-1:0] CH_VAL_SUB      = 8'h04;
	localparam logic [ADDR_W-1:0] CH_AUX_SUB      = 8'h08;

	// Timebase control fields.
	localparam int TB_EN_A_BIT  = 0;
	localparam int TB_EN_B_BIT  = 1;
	localparam int TB_JOIN_BIT  = 2;
	localparam int TB_PSC_A_LSB = 4;
	localparam int TB_PSC_B_LSB = 8;

	// Compare channel control fields.
	localparam int CMP_MODE_LSB  = 0;
	localparam int CMP_MODE_W    = 3;
	localparam int CMP_TBSEL_BIT = 3;
	localparam int CMP_EN_BIT    = 4;

	// Capture channel control and status fields.
	localparam int CAP_EDGE_LSB   = 0;
	localparam int CAP_EDGE_W     = 2;
	localparam int CAP_TBSEL_BIT  = 2;
	localparam int CAP_EN_BIT     = 3;
	localparam int CAP_IRQ_EN_BIT = 4;
	localparam int CAP_NEMPTY_BIT = 0;
	localparam int CAP_OVF_BIT    = 1;
	localparam int CAP_LEVEL_LSB  = 2;
	localparam int LEVEL_W        = 3;

	// Reset values.
	localparam logic [TB_W-1:0]   TB_PERIOD_RST = 16'hFFFF;
	localparam logic [DATA_W-1:0] RDATA_RST     = 32'h0000_0000;

	// Compare pin behaviours.
	typedef enum logic [CMP_MODE_W-1:0] {
		CMP_RISE   = 3'b000,
		CMP_FALL   = 3'b001,
		CMP_TOGGLE = 3'b010,
		CMP_SINGLE = 3'b011,
		CMP_CONT   = 3'b100,
		CMP_PWM    = 3'b101
	} tccu_cmp_mode_t;

	// Capture edge sensitivity.
	typedef enum logic [CAP_EDGE_W-1:0] {
		CAP_RISING  = 2'b00,
		CAP_FALLING = 2'b01,
		CAP_BOTH    = 2'b10
	} tccu_cap_edge_t;

	// Byte address of register sub of channel ch in the bank at base.
	function automatic logic [ADDR_W-1:0] tccu_ch_addr(input logic [ADDR_W-1:0] base, input int ch,
		input logic [ADDR_W-1:0] sub);
		logic [ADDR_W-1:0] ofs;
		ofs = ADDR_W'(ch << CH_SHIFT);
		return base + ofs + sub;
	endfunction : tccu_ch_addr

endpackage : tccu_pkg

// >>> rtl/tccu_timebase.sv
// One shared timebase: prescaler, period-reset counter and chaining input.
`timescale 1ns/1ps
module tccu_timebase #(
	parameter int W     = tccu_pkg::TB_W,
	parameter int PSC_W = tccu_pkg::PSC_W
) (
	// Clock and reset.
	input  wire logic                          sys_clk,
	input  wire logic                          rst,
	// Configuration.
	input  wire logic                          enable,
	input  wire logic [tccu_pkg::PSC_SEL_W-1:0] prescale_sel,
	input  wire logic [W-1:0]                  period,
	input  wire logic                          chain_mode,
	input  wire logic                          chain_tick,
	// Count state.
	output logic      [W-1:0]                  count,
	output logic                               wrap,
	output logic                               step
);
	import tccu_pkg::*;

	logic [PSC_W-1:0] psc;
	logic [PSC_W-1:0] psc_mask;
	logic             tick;

	// Divide by two to the power of prescale_sel; a chained counter follows the lower half's wrap instead.
	assign psc_mask = PSC_W'((1 << prescale_sel) - 1);
	assign tick     = enable & (chain_mode ? chain_tick : ((psc & psc_mask) == psc_mask));
	assign wrap     = tick & (count == period);

	// Prescaler runs only while enabled so the first tick is a full division after enabling.
	always_ff @(posedge sys_clk) begin
		if (rst || !enable) begin
			psc <= '0;
		end else begin
			psc <= psc + 1'b1;
		end
	end

	// Counter returns to zero on the next tick after it equals the period.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			count <= '0;
		end else if (tick) begin
			count <= (count == period) ? '0 : count + 1'b1;
		end
	end

	// Step marks the first cycle of a new count value, so matches fire once per value.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			step <= 1'b0;
		end else begin
			step <= tick;
		end
	end

endmodule : tccu_timebase

// >>> rtl/tccu_capture.sv
// One input capture channel: edge detector and a small FIFO of captured counts.
`timescale 1ns/1ps
module tccu_capture #(
	parameter int W     = tccu_pkg::TB_W,
	parameter int DEPTH = tccu_pkg::FIFO_DEPTH
) (
	// Clock and reset.
	input  wire logic                             sys_clk,
	input  wire logic                             rst,
	// Configuration.
	input  wire logic                             enable,
	input  wire logic [tccu_pkg::CAP_EDGE_W-1:0]  edge_mode,
	input  wire logic                             tb_sel,
	// Timebases and pin.
	input  wire logic [W-1:0]                     count_a,
	input  wire logic [W-1:0]                     count_b,
	input  wire logic                             pin,
	// Reader side.
	input  wire logic                             pop,
	output logic      [W-1:0]                     head,
	output logic      [tccu_pkg::LEVEL_W-1:0]     level,
	output logic                                  overflow,
	output logic                                  capture_event
);
	import tccu_pkg::*;

	localparam int PTR_W = $clog2(DEPTH);

	logic [W-1:0]     store [DEPTH];
	logic [PTR_W-1:0] rd_ptr;
	logic [PTR_W-1:0] wr_ptr;
	logic             pin_prev;
	logic             rise;
	logic             fall;
	logic             full;
	logic             do_pop;
	logic             do_push;

	assign rise = pin & ~pin_prev;
	assign fall = ~pin & pin_prev;

	// Edge qualification; the unused code never captures.
	always_comb begin
		capture_event = 1'b0;
		if (enable) begin
			unique case (tccu_cap_edge_t'(edge_mode))
				CAP_RISING:  capture_event = rise;
				CAP_FALLING: capture_event = fall;
				CAP_BOTH:    capture_event = rise | fall;
				default:     capture_event = 1'b0;
			endcase
		end
	end

	assign full    = (level == LEVEL_W'(DEPTH));
	assign do_pop  = pop & (level != '0);
	// A pop in the same cycle frees a slot, so a full store still accepts that capture.
	assign do_push = capture_event & (~full | do_pop);
	assign head    = store[rd_ptr];

	// Pin history for edge detection; the pin is taken as synchronous.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pin_prev <= 1'b0;
		end else begin
			pin_prev <= pin;
		end
	end

	// Store latches the selected timebase count at the event.
	always_ff @(posedge sys_clk) begin
		if (do_push) begin
			store[wr_ptr] <= tb_sel ? count_b : count_a;
		end
	end

	// Pointers and fill level; entries leave in arrival order.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rd_ptr <= '0;
			wr_ptr <= '0;
			level  <= '0;
		end else begin
			if (do_push) begin
				wr_ptr <= (wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (do_pop) begin
				rd_ptr <= (rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			end
			level <= level + LEVEL_W'(do_push) - LEVEL_W'(do_pop);
		end
	end

	// Overflow sticks until a read; an event in the read cycle is stored, not lost, so the read still clears it.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			overflow <= 1'b0;
		end else if (capture_event && !do_push) begin
			overflow <= 1'b1;
		end else if (do_pop) begin
			overflow <= 1'b0;
		end
	end

endmodule : tccu_capture

// >>> test/tccu_board.sv
// Board-side model that drives the five capture input pins.
`timescale 1ns/1ps
module tccu_board (
	// Clock.
	input  wire logic       sys_clk,
	// Requested levels and driven pins.
	input  wire logic [4:0] level,
	output logic      [4:0] pins
);
	// Pins start low so the unit never sees an unknown level.
	initial pins = 5'h0;

	// Board flops move every pin just after a clock edge, never in mid-cycle.
	always @(posedge sys_clk) begin
		pins <= level;
	end
endmodule : tccu_board

// >>> test/tccu_checker.sv
// Checker of read-port and capture timing of the capture/compare unit.
`timescale 1ns/1ps
module tccu_checker (
	// Clock and reset.
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// Register port.
	input  wire logic [7:0]  reg_addr,
	input  wire logic        reg_rd,
	input  wire logic [31:0] reg_rdata,
	// Pins.
	input  wire logic [4:0]  capture_irq,
	input  wire logic        capture_input_pin_1,
	input  wire logic        capture_input_pin_5,
	input  wire logic        compare_output_pin_1
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	chk_pins_reset: assert property ($fell(rst) |-> !compare_output_pin_1 && capture_irq == 5'h0
		&& reg_rdata == 32'h0) else $error("outputs not idle after reset");
	chk_irq_edge_one: assert property (capture_irq[0] |->
		$past(capture_input_pin_1) != $past(capture_input_pin_1, 2)) else $error("irq 0 without pin edge");
	chk_irq_edge_five: assert property (capture_irq[4] |->
		$past(capture_input_pin_5) != $past(capture_input_pin_5, 2)) else $error("irq 4 without pin edge");
	chk_count_width: assert property (reg_rd && reg_addr == 8'h0C |=>
		reg_rdata[31:16] == 16'h0) else $error("count wider than 16 bits");
	chk_level_bound: assert property (reg_rd && reg_addr == 8'h88 |=>
		reg_rdata[4:2] <= 3'h4) else $error("fill level above four");
	chk_ovf_full: assert property (reg_rd && reg_addr == 8'h88 |=>
		!reg_rdata[1] || reg_rdata[4:2] == 3'h4) else $error("overflow while not full");
	chk_nempty_level: assert property (reg_rd && reg_addr == 8'h88 |=>
		reg_rdata[0] == (reg_rdata[4:2] != 3'h0)) else $error("not-empty flag disagrees with level");
	chk_status_rsvd: assert property (reg_rd && reg_addr == 8'h88 |=>
		reg_rdata[31:5] == 27'h0) else $error("status spare bits set");
	chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0) else $error("read data outside read slot");
endmodule : tccu_checker

bind tccu_top tccu_checker u_chk (.*);

// >>> test/testbench.sv
// Self-checking bench for the timer capture/compare unit.
`timescale 1ns/1ps
module testbench;
	import tccu_pkg::*;
	logic        sys_clk   = 1'b0;
	logic        rst       = 1'b1;
	logic [7:0]  reg_addr  = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr    = 1'b0;
	logic        reg_rd    = 1'b0;
	logic [31:0] reg_rdata;
	logic [4:0]  cmp;
	logic [4:0]  cap;
	logic [4:0]  lv        = 5'h0;
	logic [4:0]  capture_irq;
	logic [31:0] d0;
	logic [31:0] d1;
	logic [39:0] r;
	logic [7:0]  a;
	int          errors = 0;
	int          total_checks = 0;
	int          cyc = 0;
	int          irq_n = 0;
	int          n;
	// Register rows: address, value written, value read back.
	localparam logic [71:0] ROWS [7] = '{{8'h04, 32'h0000_0009, 32'h0000_0009},
		{8'h08, 32'hFFFF_0009, 32'h0000_0009}, {8'h14, 32'hFFFF_FFFF, 32'h0000_0000},
		{8'h80, 32'hFFFF_FFF8, 32'h0000_0018}, {8'h90, 32'h0000_000C, 32'h0000_000C},
		{8'hA8, 32'h0000_00FF, 32'h0000_0000}, {8'h00, 32'hFFFF_F803, 32'h0000_0003}};
	// Compare rows: channel, control, value, end value, final level or high cycles in 40.
	// The continuous row is enabled while its timebase is already past the start value, so its first pulse is lost.
	localparam logic [39:0] CROWS [6] = '{{8'h0, 8'h10, 8'h5, 8'h0, 8'h1}, {8'h0, 8'h11, 8'h5, 8'h0, 8'h0},
		{8'h1, 8'h1A, 8'h5, 8'h0, 8'h14}, {8'h2, 8'h13, 8'h2, 8'h6, 8'h04},
		{8'h3, 8'h14, 8'h2, 8'h6, 8'h0D}, {8'h4, 8'h1D, 8'h3, 8'h0, 8'h0C}};
	// Status expected per edge mode after one high pulse.
	localparam logic [31:0] EDGE_ST [4] = '{32'h5, 32'h5, 32'h9, 32'h0};

	tccu_top dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .compare_output_pin_1(cmp[0]), .compare_output_pin_2(cmp[1]),
		.compare_output_pin_3(cmp[2]), .compare_output_pin_4(cmp[3]), .compare_output_pin_5(cmp[4]),
		.capture_input_pin_1(cap[0]), .capture_input_pin_2(cap[1]), .capture_input_pin_3(cap[2]),
		.capture_input_pin_4(cap[3]), .capture_input_pin_5(cap[4]), .capture_irq(capture_irq));
	tccu_board board (.sys_clk(sys_clk), .level(lv), .pins(cap));

	// Free-running 100 MHz clock.
	always #5 sys_clk = ~sys_clk;

	// Cycle ceiling cuts a hang short; irq pulses of channel 0 are counted beside it.
	always @(posedge sys_clk) begin
		cyc++;
		irq_n += int'(capture_irq[0]);
		if (cyc == 4000) begin
			errors++;
			report_and_stop();
		end
	end

	task automatic check(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : check

	task automatic wr(input logic [7:0] ad, input logic [31:0] w);
		@(posedge sys_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= ad;
		reg_wdata <= w;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe, so they are taken just after that edge.
	task automatic rd(input logic [7:0] ad, output logic [31:0] d);
		@(posedge sys_clk);
		reg_rd   <= 1'b1;
		reg_addr <= ad;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd

	// A pulse of hi cycles, then lo cycles low; rising edges of back-to-back pulses are hi+lo+1 apart.
	task automatic pulse(input int ch, input int hi, input int lo);
		@(posedge sys_clk);
		lv[ch] <= 1'b1;
		repeat (hi) @(posedge sys_clk);
		lv[ch] <= 1'b0;
		repeat (lo) @(posedge sys_clk);
	endtask : pulse

	task automatic report_and_stop;
		$display("checks=%0d errors=%0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : report_and_stop

	// Main sequence; every timebase runs with period 9, so counts repeat every ten steps.
	initial begin
		repeat (12) @(posedge sys_clk);
		rst <= 1'b0;
		rd(8'h08, d0);
		check(d0, 32'hFFFF);
		rd(8'h0C, d0);
		check(d0, 32'h0);
		for (int i = 0; i < 7; i++) begin
			wr(ROWS[i][71:64], ROWS[i][63:32]);
			rd(ROWS[i][71:64], d0);
			check(d0, ROWS[i][31:0]);
		end
		$display("done: registers");
		for (int p = 0; p < 2; p++) begin
			wr(8'h00, 32'h3 | (p << 4));
			rd(8'h0C, d0);
			rd(8'h0C, d1);
			check((d1 - d0 + 32'hA) % 32'hA, 32'(2 - p));
		end
		wr(8'h00, 32'h3);
		$display("done: prescale");
		for (int i = 0; i < 6; i++) begin
			r = CROWS[i];
			a = 8'h20 + 8'(r[39:32] << 4);
			wr(a + 8'h4, 32'(r[23:16]));
			wr(a + 8'h8, 32'(r[15:8]));
			wr(a, 32'(r[31:24]));
			n = 0;
			repeat (40) begin
				@(posedge sys_clk);
				#1 n += int'(cmp[r[39:32]]);
			end
			if (r[26:25] == 2'b00) check(32'(cmp[r[39:32]]), 32'(r[7:0]));
			else check(32'(n), 32'(r[7:0]));
		end
		wr(8'h60, 32'h5);
		repeat (3) @(posedge sys_clk);
		#1 check(32'(cmp[4]), 32'h0);
		$display("done: compare");
		irq_n = 0;
		repeat (5) pulse(0, 2, 1);
		repeat (3) @(posedge sys_clk);
		rd(8'h88, d0);
		check(d0, 32'h13);
		check(32'(irq_n), 32'h5);
		rd(8'h84, d0);
		rd(8'h88, d1);
		check(d1, 32'hD);
		repeat (3) begin
			rd(8'h84, d1);
			check((d1 - d0 + 32'hA) % 32'hA, 32'h4);
			d0 = d1;
		end
		rd(8'h88, d0);
		check(d0, 32'h0);
		$display("done: capture fifo");
		for (int m = 0; m < 4; m++) begin
			wr(8'h90, 32'hC | m);
			pulse(1, 3, 2);
			repeat (2) @(posedge sys_clk);
			rd(8'h98, d0);
			check(d0, EDGE_ST[m]);
			rd(8'h94, d0);
			rd(8'h94, d1);
			if (m == 2) check((d1 - d0 + 32'hA) % 32'hA, 32'h3);
		end
		wr(8'hC0, 32'h1A);
		pulse(4, 2, 2);
		repeat (2) @(posedge sys_clk);
		rd(8'hC8, d0);
		check(d0, 32'h9);
		$display("done: edge modes");
		// Joined, timebase B steps once per wrap of A, that is once every ten cycles here.
		wr(8'h00, 32'h7);
		rd(8'h10, d0);
		repeat (8) @(posedge sys_clk);
		rd(8'h10, d1);
		check((d1 - d0 + 32'hA) % 32'hA, 32'h1);
		$display("done: join");
		@(posedge sys_clk);
		rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		rd(8'h04, d0);
		check(d0, 32'hFFFF);
		check(32'(cmp), 32'h0);
		$display("done: second reset");
		report_and_stop();
	end
endmodule : testbench
